/* File: hdl/charger_pkg.sv */
// Constants for the charger control and charger interrupt registers.
// Assumes an 8-bit register port with one-cycle read latency.
package charger_pkg;

   // ==========================================================
   // Bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] KEEP_ALIVE_OFS = 8'h91;
   localparam logic [7:0] CTRL_OFS = 8'hA1;
   localparam logic [7:0] EVT_STATUS_OFS = 8'hA8;
   localparam logic [7:0] EVT_ENABLE_OFS = 8'hA9;

   // ==========================================================
   // Reset values
   localparam logic KA_A_RST = 1'b0;
   localparam logic KA_B_RST = 1'b0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] ARM_RST = 4'h0;
   localparam logic [7:0] ENABLE_RST = 8'h00;

   // ==========================================================
   // Keep-alive register fields
   localparam int KA_A_BIT = 7;
   localparam int KA_B_BIT = 6;

   // ==========================================================
   // Charger control fields
   localparam int SUSPEND_BIT = 7;
   localparam int TOT_SEL_LSB = 4;
   localparam int PRE_SEL_LSB = 2;
   localparam int LEVEL_BIT = 1;
   localparam int OVP_BIT = 0;

   // ==========================================================
   // Event status fields; arm group g sits at bit ARM_LSB + g
   localparam int ARM_LSB = 4;
   localparam int GRP_EOC = 0;
   localparam int GRP_INPUT = 1;
   localparam int GRP_TEMP = 2;
   localparam int GRP_TIMER = 3;
   localparam int TIMER_FLAG_BIT = 3;
   localparam int TEMP_FLAG_BIT = 2;
   localparam int INPUT_FLAG_BIT = 1;
   localparam int EOC_FLAG_BIT = 0;

   // ==========================================================
   // Event enable fields
   localparam int EN_TOT = 7;
   localparam int EN_TEMP_IN = 6;
   localparam int EN_INPUT_IN = 5;
   localparam int EN_EOC_IN = 4;
   localparam int EN_PRE = 3;
   localparam int EN_TEMP_OUT = 2;
   localparam int EN_INPUT_OUT = 1;
   localparam int EN_EOC_OUT = 0;

   // ==========================================================
   // Edge detector slots
   localparam int NUM_EDGES = 5;
   localparam int EV_TOT = 0;
   localparam int EV_PRE = 1;
   localparam int EV_TEMP = 2;
   localparam int EV_INPUT = 3;
   localparam int EV_EOC = 4;

endpackage : charger_pkg

/* File: hdl/edge_if.sv */
// Level in, rise and fall pulses out, for one watched condition.
// Assumes one clock shared by both ends.
interface edge_if;
   logic level;
   logic rise;
   logic fall;

   modport detector (input level, output rise, output fall);
   modport user (output level, input rise, input fall);
endinterface : edge_if

/* File: hdl/edge_event.sv */
// Edge detector for one status level.
// Assumes level is synchronous to clk_sys; no edge in the first cycle after reset.
module edge_event (
   input wire logic clk_sys,
   input wire logic rst_n,
   edge_if.detector ev
);

   typedef struct packed {
      logic prev;
      logic primed;
   } edge_s;

   edge_s st_reg;
   edge_s st_next;

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.prev = ev.level;
      st_next.primed = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Pulses
   assign ev.rise = st_reg.primed & ev.level & ~st_reg.prev;
   assign ev.fall = st_reg.primed & ~ev.level & st_reg.prev;

endmodule : edge_event

/* File: hdl/charger_ctrl_irq_regs.sv */
// Keep-alive enables, charger control and charger interrupt registers.
// Assumes a synchronous register port and status levels synchronous to clk_sys.
//
// The plain strobed port is this design's own decision.
module charger_ctrl_irq_regs (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic total_timeout,
   input wire logic precondition_timeout,
   input wire logic temperature_valid,
   input wire logic charger_input_valid,
   input wire logic end_of_charge,
   output logic keep_alive_a_on,
   output logic keep_alive_b_on,
   output logic charge_suspend,
   output logic [1:0] total_timeout_select,
   output logic [1:0] precondition_timeout_select,
   output logic charge_current_level,
   output logic input_overvoltage_select,
   output logic irq
);

   // ==========================================================
   // Reset release
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Edge detectors
   logic [charger_pkg::NUM_EDGES-1:0] levels;
   logic [charger_pkg::NUM_EDGES-1:0] rises;
   logic [charger_pkg::NUM_EDGES-1:0] falls;

   assign levels[charger_pkg::EV_TOT] = total_timeout;
   assign levels[charger_pkg::EV_PRE] = precondition_timeout;
   assign levels[charger_pkg::EV_TEMP] = temperature_valid;
   assign levels[charger_pkg::EV_INPUT] = charger_input_valid;
   assign levels[charger_pkg::EV_EOC] = end_of_charge;

   edge_if ev_if [charger_pkg::NUM_EDGES] ();

   genvar g;
   generate
      for (g = 0; g < charger_pkg::NUM_EDGES; g++) begin : gen_edge
         assign ev_if[g].level = levels[g];
         assign rises[g] = ev_if[g].rise;
         assign falls[g] = ev_if[g].fall;
         edge_event u_edge (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .ev(ev_if[g])
         );
      end
   endgenerate

   // ==========================================================
   // State
   typedef struct packed {
      logic ka_a;
      logic ka_b;
      logic suspend;
      logic [1:0] tot_sel;
      logic [1:0] pre_sel;
      logic level;
      logic ovp;
      logic [3:0] arm;
      logic [3:0] pend;
      logic [7:0] en;
      logic [7:0] rdata;
      logic irq;
   } state_s;

   state_s st_reg;
   state_s st_next;

   logic wr_ka;
   logic wr_ctrl;
   logic wr_status;
   logic wr_enable;
   logic rd_status;
   logic timer_flag;
   logic [3:0] hit;
   logic [3:0] clr;

   assign wr_ka = wr && addr == charger_pkg::KEEP_ALIVE_OFS;
   assign wr_ctrl = wr && addr == charger_pkg::CTRL_OFS;
   assign wr_status = wr && addr == charger_pkg::EVT_STATUS_OFS;
   assign wr_enable = wr && addr == charger_pkg::EVT_ENABLE_OFS;
   assign rd_status = rd && addr == charger_pkg::EVT_STATUS_OFS;

   // Either safety timer expired
   assign timer_flag = total_timeout | precondition_timeout;

   // ==========================================================
   // Event qualification
   always_comb begin
      hit[charger_pkg::GRP_TIMER] = st_reg.arm[charger_pkg::GRP_TIMER] &
         ((st_reg.en[charger_pkg::EN_TOT] & rises[charger_pkg::EV_TOT]) |
          (st_reg.en[charger_pkg::EN_PRE] & rises[charger_pkg::EV_PRE]));
      hit[charger_pkg::GRP_TEMP] = st_reg.arm[charger_pkg::GRP_TEMP] &
         ((st_reg.en[charger_pkg::EN_TEMP_IN] & rises[charger_pkg::EV_TEMP]) |
          (st_reg.en[charger_pkg::EN_TEMP_OUT] & falls[charger_pkg::EV_TEMP]));
      hit[charger_pkg::GRP_INPUT] = st_reg.arm[charger_pkg::GRP_INPUT] &
         ((st_reg.en[charger_pkg::EN_INPUT_IN] & rises[charger_pkg::EV_INPUT]) |
          (st_reg.en[charger_pkg::EN_INPUT_OUT] & falls[charger_pkg::EV_INPUT]));
      hit[charger_pkg::GRP_EOC] = st_reg.arm[charger_pkg::GRP_EOC] &
         ((st_reg.en[charger_pkg::EN_EOC_IN] & rises[charger_pkg::EV_EOC]) |
          (st_reg.en[charger_pkg::EN_EOC_OUT] & falls[charger_pkg::EV_EOC]));
   end

   // Read clears status; writing an arm bit as 0 also drops it
   always_comb begin
      clr = {4{rd_status}};
      if (wr_status) begin
         clr = clr | ~wdata[charger_pkg::ARM_LSB +: 4];
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      if (wr_ka) begin
         st_next.ka_a = wdata[charger_pkg::KA_A_BIT];
         st_next.ka_b = wdata[charger_pkg::KA_B_BIT];
      end
      if (wr_ctrl) begin
         st_next.suspend = wdata[charger_pkg::SUSPEND_BIT];
         st_next.tot_sel = wdata[charger_pkg::TOT_SEL_LSB +: 2];
         st_next.pre_sel = wdata[charger_pkg::PRE_SEL_LSB +: 2];
         st_next.level = wdata[charger_pkg::LEVEL_BIT];
         st_next.ovp = wdata[charger_pkg::OVP_BIT];
      end
      if (wr_status) begin
         st_next.arm = wdata[charger_pkg::ARM_LSB +: 4];
      end
      if (wr_enable) begin
         st_next.en = wdata;
      end
      // Set wins over clear
      st_next.pend = (st_reg.pend & ~clr) | hit;
      st_next.irq = |st_next.pend;
      st_next.rdata = 8'h00;
      if (rd) begin
         case (addr)
            charger_pkg::KEEP_ALIVE_OFS: begin
               st_next.rdata = {st_reg.ka_a, st_reg.ka_b, 6'h00};
            end
            charger_pkg::CTRL_OFS: begin
               st_next.rdata = {st_reg.suspend, 1'b0, st_reg.tot_sel, st_reg.pre_sel,
                  st_reg.level, st_reg.ovp};
            end
            charger_pkg::EVT_STATUS_OFS: begin
               st_next.rdata = {st_reg.pend, timer_flag, temperature_valid,
                  charger_input_valid, end_of_charge};
            end
            charger_pkg::EVT_ENABLE_OFS: begin
               st_next.rdata = st_reg.en;
            end
            default: begin
               st_next.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.ka_a <= charger_pkg::KA_A_RST;
         st_reg.ka_b <= charger_pkg::KA_B_RST;
         st_reg.suspend <= charger_pkg::CTRL_RST[charger_pkg::SUSPEND_BIT];
         st_reg.tot_sel <= charger_pkg::CTRL_RST[charger_pkg::TOT_SEL_LSB +: 2];
         st_reg.pre_sel <= charger_pkg::CTRL_RST[charger_pkg::PRE_SEL_LSB +: 2];
         st_reg.level <= charger_pkg::CTRL_RST[charger_pkg::LEVEL_BIT];
         st_reg.ovp <= charger_pkg::CTRL_RST[charger_pkg::OVP_BIT];
         st_reg.arm <= charger_pkg::ARM_RST;
         st_reg.pend <= 4'h0;
         st_reg.en <= charger_pkg::ENABLE_RST;
         st_reg.rdata <= 8'h00;
         st_reg.irq <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign rdata = st_reg.rdata;
   assign keep_alive_a_on = st_reg.ka_a;
   assign keep_alive_b_on = st_reg.ka_b;
   assign charge_suspend = st_reg.suspend;
   assign total_timeout_select = st_reg.tot_sel;
   assign precondition_timeout_select = st_reg.pre_sel;
   assign charge_current_level = st_reg.level;
   assign input_overvoltage_select = st_reg.ovp;
   assign irq = st_reg.irq;

   // ==========================================================
   // Assertions
   logic live_reg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         live_reg <= 1'b0;
      end else begin
         live_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_tot_hit;
      live_reg && st_reg.arm[3] && st_reg.en[7] && $rose(total_timeout);
   endsequence
   sequence s_pre_hit;
      live_reg && st_reg.arm[3] && st_reg.en[3] && $rose(precondition_timeout);
   endsequence
   sequence s_temp_in;
      live_reg && st_reg.arm[2] && st_reg.en[6] && $rose(temperature_valid);
   endsequence
   sequence s_temp_out;
      live_reg && st_reg.arm[2] && st_reg.en[2] && $fell(temperature_valid);
   endsequence
   sequence s_input_in;
      live_reg && st_reg.arm[1] && st_reg.en[5] && $rose(charger_input_valid);
   endsequence
   sequence s_input_out;
      live_reg && st_reg.arm[1] && st_reg.en[1] && $fell(charger_input_valid);
   endsequence
   sequence s_eoc_in;
      live_reg && st_reg.arm[0] && st_reg.en[4] && $rose(end_of_charge);
   endsequence
   sequence s_eoc_out;
      live_reg && st_reg.arm[0] && st_reg.en[0] && $fell(end_of_charge);
   endsequence
   sequence s_status_read;
      rd && addr == charger_pkg::EVT_STATUS_OFS;
   endsequence
   sequence s_no_event;
      hit == 4'h0;
   endsequence

   ka_a_write_a: assert property (wr_ka |=> keep_alive_a_on == $past(wdata[7]))
      else $error("keep-alive A enable not written");
   ka_b_write_a: assert property (wr_ka |=> keep_alive_b_on == $past(wdata[6]))
      else $error("keep-alive B enable not written");
   suspend_write_a: assert property (wr_ctrl |=> charge_suspend == $past(wdata[7]))
      else $error("charge suspend not written");
   total_sel_a: assert property (wr_ctrl |=> total_timeout_select == $past(wdata[5:4]))
      else $error("total time-out select not written");
   pre_sel_a: assert property (wr_ctrl |=> precondition_timeout_select == $past(wdata[3:2]))
      else $error("precondition time-out select not written");
   level_sel_a: assert property (wr_ctrl |=> charge_current_level == $past(wdata[1]))
      else $error("charge current level not written");
   ovp_sel_a: assert property (wr_ctrl |=> input_overvoltage_select == $past(wdata[0]))
      else $error("over-voltage select not written");
   timer_arm_a: assert property (wr_status |=> st_reg.arm[3] == $past(wdata[7]))
      else $error("timer arm not written");
   temp_arm_a: assert property (wr_status |=> st_reg.arm[2] == $past(wdata[6]))
      else $error("temperature arm not written");
   input_arm_a: assert property (wr_status |=> st_reg.arm[1] == $past(wdata[5]))
      else $error("input arm not written");
   eoc_arm_a: assert property (wr_status |=> st_reg.arm[0] == $past(wdata[4]))
      else $error("charge-state arm not written");
   status_read_a: assert property (s_status_read |=> rdata[7:4] == $past(st_reg.pend))
      else $error("interrupt status read wrong");
   timer_flag_a: assert property (s_status_read |=> rdata[3] == $past(timer_flag))
      else $error("timer flag read wrong");
   temp_flag_a: assert property (s_status_read |=> rdata[2] == $past(temperature_valid))
      else $error("temperature flag read wrong");
   input_flag_a: assert property (s_status_read |=> rdata[1] == $past(charger_input_valid))
      else $error("input flag read wrong");
   eoc_flag_a: assert property (s_status_read |=> rdata[0] == $past(end_of_charge))
      else $error("end-of-charge flag read wrong");
   tot_raise_a: assert property (s_tot_hit |=> st_reg.pend[3] && irq)
      else $error("total time-out not raised");
   temp_in_raise_a: assert property (s_temp_in |=> st_reg.pend[2] && irq)
      else $error("temperature entry not raised");
   input_in_raise_a: assert property (s_input_in |=> st_reg.pend[1] && irq)
      else $error("input valid not raised");
   eoc_in_raise_a: assert property (s_eoc_in |=> st_reg.pend[0] && irq)
      else $error("end-of-charge entry not raised");
   pre_raise_a: assert property (s_pre_hit |=> st_reg.pend[3] && irq)
      else $error("precondition time-out not raised");
   temp_out_raise_a: assert property (s_temp_out |=> st_reg.pend[2] && irq)
      else $error("temperature exit not raised");
   input_out_raise_a: assert property (s_input_out |=> st_reg.pend[1] && irq)
      else $error("input invalid not raised");
   eoc_out_raise_a: assert property (s_eoc_out |=> st_reg.pend[0] && irq)
      else $error("end-of-charge exit not raised");
   irq_or_a: assert property (irq == (st_reg.pend != 4'h0))
      else $error("interrupt output differs from status");
   read_clear_a: assert property ((s_status_read and s_no_event) |=> st_reg.pend == 4'h0)
      else $error("status read did not clear");
   irq_quiet_a: assert property ((!irq && hit == 4'h0) |=> !irq)
      else $error("interrupt raised without an event");
   irq_hold_a: assert property ((irq && !rd_status && !wr_status) |=> irq)
      else $error("interrupt dropped without a clear");
   disarm_clear_a: assert property ((wr_status && hit == 4'h0) |=>
      (st_reg.pend & ~$past(wdata[7:4])) == 4'h0)
      else $error("disarmed status still pending");

endmodule : charger_ctrl_irq_regs

/* File: test/charger_status_model.sv */
// Charger front end model that drives the five status levels.
// Assumes the bench gives the wanted levels; they move just after a clock edge.
module charger_status_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [4:0] level_tgt,
   output logic total_timeout,
   output logic precondition_timeout,
   output logic temperature_valid,
   output logic charger_input_valid,
   output logic end_of_charge
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Level outputs
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {total_timeout, precondition_timeout, temperature_valid} <= 3'h0;
         {charger_input_valid, end_of_charge} <= 2'h0;
      end else begin
         {total_timeout, precondition_timeout, temperature_valid} <= level_tgt[4:2];
         {charger_input_valid, end_of_charge} <= level_tgt[1:0];
      end
   end
endmodule : charger_status_model

/* File: test/tb_charger_ctrl_irq_regs.sv */
// Self-checking bench for the charger control and interrupt registers.
// Assumes the register port contract: read data in the cycle after rd only.
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module tb_charger_ctrl_irq_regs;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] lv_tgt = 5'h00;
   logic [7:0] rdata;
   logic tot, pre, temp, inp, eoc;
   logic ka_a, ka_b, susp, lvl, ovp, irq;
   logic [1:0] tsel, psel;
   logic [9:0] outs;
   logic [7:0] ka_exp, ctrl_exp, en_exp;
   int mismatches = 0;
   int checks = 0;
   logic [2:0] idx_tab [8] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0};
   logic [7:0] addr_tab [8] = '{8'h91, 8'hA1, 8'hA9, 8'h90, 8'h92, 8'hA0, 8'hAA, 8'hFF};

   assign outs = {ka_a, ka_b, susp, 1'b0, tsel, psel, lvl, ovp};
   always #4 clk_sys = ~clk_sys;

   charger_status_model charger_model (.clk_sys(clk_sys), .resetn(resetn), .level_tgt(lv_tgt),
      .total_timeout(tot), .precondition_timeout(pre), .temperature_valid(temp),
      .charger_input_valid(inp), .end_of_charge(eoc));

   charger_ctrl_irq_regs DUT (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .total_timeout(tot), .precondition_timeout(pre),
      .temperature_valid(temp), .charger_input_valid(inp), .end_of_charge(eoc),
      .keep_alive_a_on(ka_a), .keep_alive_b_on(ka_b), .charge_suspend(susp),
      .total_timeout_select(tsel), .precondition_timeout_select(psel),
      .charge_current_level(lvl), .input_overvoltage_select(ovp), .irq(irq));

   // ==========================================================
   // Expectation functions
   function automatic logic [3:0] flags(input logic [4:0] l);
      return {l[4] | l[3], l[2], l[1], l[0]};
   endfunction : flags

   function automatic logic [7:0] exp_read(input logic [7:0] a);
      case (a)
         charger_pkg::KEEP_ALIVE_OFS: return ka_exp & 8'hC0;
         charger_pkg::CTRL_OFS: return ctrl_exp & 8'hBF;
         charger_pkg::EVT_ENABLE_OFS: return en_exp;
         default: return 8'h00;
      endcase
   endfunction : exp_read

   // ==========================================================
   // Bus and stimulus tasks
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask : rd_reg

   task automatic set_lv(input logic [4:0] v);
      @(posedge clk_sys);
      lv_tgt <= v;
   endtask : set_lv

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : idle

   task automatic wait_irq();
      int i;
      for (i = 0; i < 8 && irq !== 1'b1; i++) @(negedge clk_sys);
      if (irq !== 1'b1) begin
         mismatches++;
         $display("[ERR] irq wait exp 1 got %b", irq);
         close_out();
      end
   endtask : wait_irq

   task automatic close_out();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] d;
      logic [7:0] a;
      logic [7:0] v;
      logic [4:0] m;
      int i;
      int k;
      void'($urandom(38));
      ka_exp = 8'h00;
      ctrl_exp = 8'h00;
      en_exp = 8'h00;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      idle(3);
      for (i = 0; i < 8; i++) begin
         rd_reg(addr_tab[i], d);
         `CHK("reset read", exp_read(addr_tab[i]), d);
      end
      rd_reg(charger_pkg::EVT_STATUS_OFS, d);
      `CHK("reset status", 8'h00, d);
      `CHK("reset outs", 10'h000, outs);
      for (i = 0; i < 24; i++) begin
         a = addr_tab[i % 8];
         v = (i < 8) ? 8'hFF : ((i < 16) ? 8'h00 : 8'($urandom));
         wr_reg(a, v);
         case (a)
            charger_pkg::KEEP_ALIVE_OFS: ka_exp = v;
            charger_pkg::CTRL_OFS: ctrl_exp = v;
            charger_pkg::EVT_ENABLE_OFS: en_exp = v;
            default: ;
         endcase
         rd_reg(a, d);
         `CHK("reg read", exp_read(a), d);
         `CHK("ctrl outs", {ka_exp[7:6], ctrl_exp & 8'hBF}, outs);
      end
      for (i = 0; i < 10; i++) begin
         m = 5'($urandom);
         if (i < 7) m[1] = 1'b1;
         set_lv(m);
         idle(3);
         rd_reg(charger_pkg::EVT_STATUS_OFS, d);
         `CHK("live flags", {4'h0, flags(m)}, d);
      end
      for (k = 0; k < 8; k++) begin
         m = 5'(5'h01 << idx_tab[k]);
         set_lv((k <= 4) ? 5'h00 : m);
         wr_reg(charger_pkg::EVT_ENABLE_OFS, 8'(8'h01 << (7 - k)));
         wr_reg(charger_pkg::EVT_STATUS_OFS, 8'h00);
         idle(6);
         rd_reg(charger_pkg::EVT_STATUS_OFS, d);
         set_lv(lv_tgt ^ m);
         idle(6);
         `CHK("irq unarmed", 1'b0, irq);
         set_lv(lv_tgt ^ m);
         idle(6);
         wr_reg(charger_pkg::EVT_STATUS_OFS, 8'(8'h01 << (7 - k % 4)));
         rd_reg(charger_pkg::EVT_STATUS_OFS, d);
         set_lv(lv_tgt ^ m);
         wait_irq();
         `CHK("irq armed", 1'b1, irq);
         rd_reg(charger_pkg::EVT_STATUS_OFS, d);
         `CHK("pending", 8'(8'h01 << (7 - k % 4)) | {4'h0, flags(lv_tgt)}, d);
         `CHK("irq cleared", 1'b0, irq);
         set_lv(lv_tgt ^ m);
         idle(6);
         `CHK("irq other edge", 1'b0, irq);
      end
      set_lv(5'h00);
      wr_reg(charger_pkg::EVT_ENABLE_OFS, 8'hFF);
      wr_reg(charger_pkg::EVT_STATUS_OFS, 8'hF0);
      idle(6);
      rd_reg(charger_pkg::EVT_STATUS_OFS, d);
      set_lv(5'h1F);
      wait_irq();
      rd_reg(charger_pkg::EVT_STATUS_OFS, d);
      `CHK("all pending", 8'hFF, d);
      wr_reg(charger_pkg::KEEP_ALIVE_OFS, 8'hC0);
      @(posedge clk_sys);
      resetn <= 1'b0;
      idle(2);
      resetn <= 1'b1;
      idle(3);
      ka_exp = 8'h00;
      ctrl_exp = 8'h00;
      en_exp = 8'h00;
      rd_reg(charger_pkg::KEEP_ALIVE_OFS, d);
      `CHK("second reset", 8'h00, d);
      `CHK("second reset irq", 1'b0, irq);
      close_out();
   end
endmodule : tb_charger_ctrl_irq_regs
